// File: hw/buck_loop_pkg.sv
// Purpose: Shared constants and types of the buck voltage-loop compensator
// Assumes: One core clock; all widths in bits, times in their own units
// Notes: Numbers shared by the compensator and the bench are named here once; sample_fifo keeps its own
package buck_loop_pkg;

  // Clocking and switching rates
  localparam int CORE_CLK_HZ = 250_000_000;
  localparam int PWM_CLK_HZ = 80_000_000;
  localparam int SWITCH_HZ = 200_000;
  // Core cycles per PWM master tick, rounded down (no integer ratio exists)
  localparam int TICK_DIV = CORE_CLK_HZ / PWM_CLK_HZ;
  localparam int PERIOD_TICKS = PWM_CLK_HZ / SWITCH_HZ;

  // Fine pulse extender figures
  localparam int FINE_STEP_PS = 150;
  localparam int FINE_SUBSTEPS = 256;
  localparam int FINE_SHIFT = 8;
  localparam logic [7:0] FINE_FULL_SCALE = 8'h52;
  localparam logic [7:0] FINE_BYTE_MASK = 8'hff;

  // Data widths
  localparam int ADC_W = 12;
  localparam int ERR_W = ADC_W + 1;
  localparam int COEF_W = 16;
  localparam int U_W = 32;
  localparam int PROD_W = COEF_W + U_W;
  localparam int ACC_W = 56;
  localparam int OUT_W = 24;
  localparam int COARSE_W = 16;
  localparam int FINE_W = 8;
  localparam int CNT_W = 16;
  localparam int SHIFT_W = 6;
  localparam int TAP_W = 3;

  // Field positions of the 24-bit output
  localparam int COARSE_LSB = 8;
  localparam int FINE_MSB = 7;

  // Tap sequencing: b0, b1..b3, a1..a3
  localparam logic [TAP_W-1:0] TAP_LAST = 3'h6;
  localparam logic [TAP_W-1:0] TAP_FIRST_POLE = 3'h4;

  // Reset values
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [U_W-1:0] HIST_RESET = 32'h0000_0000;
  localparam logic [ERR_W-1:0] ERR_RESET = 13'h0000;

  // Evaluation sequencer states
  typedef enum logic [3:0] {
    EVAL_IDLE = 4'b0001,
    EVAL_MAC = 4'b0010,
    EVAL_SAT = 4'b0100,
    EVAL_LOAD = 4'b1000
  } eval_state_t;

endpackage

// File: hw/sample_fifo.sv
// Purpose: Small valid/ready FIFO holding ADC samples ahead of the filter
// Assumes: Single clock, synchronous active-high reset
// Notes: Full refuses writes, even with a pop in the same cycle; otherwise a pop and push in the same cycle both succeed
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;
  } fifo_t;

  fifo_t q;
  fifo_t d;
  logic push;
  logic pop;

  // Pointer step with wrap for non power-of-two depths
  function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
    nextPtr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Honest flags straight from the occupancy count
  assign inReady = (q.count != CNT_W'(DEPTH));
  assign outValid = (q.count != '0);
  assign outData = q.mem[q.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Next state
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wrPtr] = inData;
      d.wrPtr = nextPtr(q.wrPtr);
    end
    if (pop)
    begin
      d.rdPtr = nextPtr(q.rdPtr);
    end
    if (push && !pop)
    begin
      d.count = q.count + 1'b1;
    end
    else if (pop && !push)
    begin
      d.count = q.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// File: hw/buck_voltage_loop_compensator.sv
// Purpose: Per-period voltage loop for a buck stage: sample trigger, three-pole filter, duty update
// Assumes: ADC and fine pulse extender are logic on core_clk; coefficients are static
// Notes: One shared multiplier walks the seven taps, so an evaluation takes ten cycles
//
// Functional notes
// - The PWM counter raises a conversion-start pulse whenever it equals the sample compare value.
// - The sample compare follows the period value unless a custom value is selected.
// - Each valid conversion result launches one filter evaluation that ends in a done pulse.
// - Sampling and evaluation happen once per switching period, pacing the loop at that rate.
// - The error term is the reference minus the oldest queued ADC sample.
// - The output sums b0 on the new error, b1..b3 on past errors and a1..a3 on past outputs.
// - The sum is clamped to +/- the maximum, kept as history, then floored for the PWM.
// - The 24-bit result gives the coarse compare in bits 23..8 and the fine fraction in bits 7..0.
// - The fine compare is the low byte times 82, shifted right by eight.
// - New compares sit in shadows and move to the active set at the period boundary on request.
// - The fine compare drives the extender that stretches the coarse pulse in 150 ps steps.
// - The PWM master tick models 80 MHz with 256 fine sub-steps per tick.
// - PERIOD_DEFAULT is unused; the periodValue input sets the switching rate, which is also the evaluation rate.
`timescale 1ns/1ps
`default_nettype none
module buck_voltage_loop_compensator
  import buck_loop_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter logic [CNT_W-1:0] PERIOD_DEFAULT = CNT_W'(PERIOD_TICKS)
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [CNT_W-1:0] periodValue,
  input wire logic sampleCompareSel,
  input wire logic [CNT_W-1:0] sampleCompare,
  output logic adcStart,
  input wire logic adcValid,
  output logic adcReady,
  input wire logic [ADC_W-1:0] adcData,
  input wire logic [ADC_W-1:0] reference,
  input wire logic signed [COEF_W-1:0] coefB0,
  input wire logic signed [COEF_W-1:0] coefB1,
  input wire logic signed [COEF_W-1:0] coefB2,
  input wire logic signed [COEF_W-1:0] coefB3,
  input wire logic signed [COEF_W-1:0] coefA1,
  input wire logic signed [COEF_W-1:0] coefA2,
  input wire logic signed [COEF_W-1:0] coefA3,
  input wire logic [SHIFT_W-1:0] accShift,
  input wire logic signed [U_W-1:0] maxLimit,
  input wire logic signed [U_W-1:0] minLimit,
  output logic evalDone,
  output logic [COARSE_W-1:0] coarseCompare,
  output logic [FINE_W-1:0] fineCompare,
  output logic pwmOut
);

  typedef struct packed {
    eval_state_t st;
    logic [7:0] tickCnt;
    logic tick;
    logic [CNT_W-1:0] cnt;
    logic adcStart;
    logic [TAP_W-1:0] tap;
    logic [ERR_W-1:0] eCur;
    logic [3:1][ERR_W-1:0] eHist;
    logic [3:1][U_W-1:0] uHist;
    logic [ACC_W-1:0] acc;
    logic [OUT_W-1:0] outVal;
    logic [COARSE_W-1:0] shCoarse;
    logic [FINE_W-1:0] shFine;
    logic xferReq;
    logic [COARSE_W-1:0] actCoarse;
    logic [FINE_W-1:0] actFine;
    logic pwm;
  } core_t;

  core_t q;
  core_t d;

  logic sampleValid;
  logic samplePop;
  logic [ADC_W-1:0] sampleData;
  logic [CNT_W-1:0] sampleMatch;
  logic boundary;
  logic signed [COEF_W-1:0] coefSel;
  logic signed [U_W-1:0] dataSel;
  logic signed [PROD_W-1:0] prod;
  logic signed [ACC_W-1:0] scaled;
  logic signed [ACC_W-1:0] uClamped;
  logic signed [ACC_W-1:0] uFloored;
  logic [15:0] fineProd;

  // Clamp a wide signed value between two limits
  function automatic logic signed [ACC_W-1:0] clampSigned(
    input logic signed [ACC_W-1:0] v,
    input logic signed [ACC_W-1:0] lo,
    input logic signed [ACC_W-1:0] hi
  );
    if (v > hi)
    begin
      clampSigned = hi;
    end
    else if (v < lo)
    begin
      clampSigned = lo;
    end
    else
    begin
      clampSigned = v;
    end
  endfunction

  // Samples wait here while the filter is busy; full backs up into the ADC
  sample_fifo #(
    .WIDTH(ADC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_sample_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .inValid(adcValid),
    .inReady(adcReady),
    .inData(adcData),
    .outValid(sampleValid),
    .outReady(samplePop),
    .outData(sampleData)
  );

  // Trigger point defaults to the period so sampling lands at the cycle end
  assign sampleMatch = sampleCompareSel ? sampleCompare : periodValue;
  assign boundary = q.tick && (q.cnt == periodValue);
  assign samplePop = sampleValid && (q.st == EVAL_IDLE);

  // Tap operand select for the shared multiplier
  always_comb
  begin
    coefSel = coefB0;
    dataSel = U_W'($signed(q.eCur));
    case (q.tap)
      3'h0:
      begin
        coefSel = coefB0;
        dataSel = U_W'($signed(q.eCur));
      end
      3'h1:
      begin
        coefSel = coefB1;
        dataSel = U_W'($signed(q.eHist[1]));
      end
      3'h2:
      begin
        coefSel = coefB2;
        dataSel = U_W'($signed(q.eHist[2]));
      end
      3'h3:
      begin
        coefSel = coefB3;
        dataSel = U_W'($signed(q.eHist[3]));
      end
      3'h4:
      begin
        coefSel = coefA1;
        dataSel = $signed(q.uHist[1]);
      end
      3'h5:
      begin
        coefSel = coefA2;
        dataSel = $signed(q.uHist[2]);
      end
      3'h6:
      begin
        coefSel = coefA3;
        dataSel = $signed(q.uHist[3]);
      end
      default:
      begin
        coefSel = '0;
        dataSel = '0;
      end
    endcase
  end

  // Saturation arithmetic on the finished sum
  assign prod = coefSel * dataSel;
  assign scaled = $signed(q.acc) >>> accShift;
  assign uClamped = clampSigned(scaled, -ACC_W'(maxLimit), ACC_W'(maxLimit));
  // Floor only for the PWM value; history keeps the two-sided clamp
  assign uFloored = clampSigned(uClamped, ACC_W'(minLimit), ACC_W'(maxLimit));
  // Divide by 256 rather than 255: a shift costs nothing, error under half a step
  assign fineProd = (16'(uFloored[FINE_MSB:0]) & 16'(FINE_BYTE_MASK))
    * 16'(FINE_FULL_SCALE);

  // Next state of timer, sequencer and shadows
  always_comb
  begin
    d = q;
    d.adcStart = 1'b0;
    // Divider makes the PWM master tick enable
    d.tick = (q.tickCnt == 8'(TICK_DIV - 1));
    d.tickCnt = d.tick ? 8'h00 : q.tickCnt + 8'h01;
    if (q.tick)
    begin
      d.cnt = (q.cnt == periodValue) ? CNT_RESET : q.cnt + 1'b1;
      d.adcStart = (q.cnt == sampleMatch);
    end
    d.pwm = (q.cnt < q.actCoarse);
    // Period boundary: shadows go live only when requested, so no mid-cycle glitch
    if (boundary && q.xferReq)
    begin
      d.actCoarse = q.shCoarse;
      d.actFine = q.shFine;
      d.xferReq = 1'b0;
    end
    case (q.st)
      EVAL_IDLE:
      begin
        if (samplePop)
        begin
          d.eCur = ERR_W'({1'b0, reference}) - ERR_W'({1'b0, sampleData});
          d.acc = '0;
          d.tap = '0;
          d.st = EVAL_MAC;
        end
      end
      EVAL_MAC:
      begin
        d.acc = q.acc + ACC_W'(prod);
        d.tap = q.tap + 1'b1;
        if (q.tap == TAP_LAST)
        begin
          d.st = EVAL_SAT;
        end
      end
      EVAL_SAT:
      begin
        d.uHist[3] = q.uHist[2];
        d.uHist[2] = q.uHist[1];
        d.uHist[1] = U_W'(uClamped);
        d.eHist[3] = q.eHist[2];
        d.eHist[2] = q.eHist[1];
        d.eHist[1] = q.eCur;
        d.outVal = OUT_W'(uFloored);
        d.shCoarse = uFloored[OUT_W-1:COARSE_LSB];
        d.shFine = fineProd[15:FINE_SHIFT];
        // Set after the boundary clear so a same-cycle request is not lost
        d.xferReq = 1'b1;
        d.st = EVAL_LOAD;
      end
      EVAL_LOAD:
      begin
        d.st = EVAL_IDLE;
      end
      default:
      begin
        d.st = EVAL_IDLE;
      end
    endcase
  end

  // Single state register; reset clears history and blocks updates
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      q <= '0;
      q.st <= EVAL_IDLE;
      q.cnt <= CNT_RESET;
      q.eCur <= ERR_RESET;
      q.eHist <= {3{ERR_RESET}};
      q.uHist <= {3{HIST_RESET}};
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register, except the done decode
  assign adcStart = q.adcStart;
  assign evalDone = (q.st == EVAL_LOAD);
  assign coarseCompare = q.actCoarse;
  assign fineCompare = q.actFine;
  assign pwmOut = q.pwm;

  // Checks except a_reset_clear sleep through reset; history is only meaningful once running
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_adc_start_match: assert property (
    q.tick && (q.cnt == sampleMatch) |=> adcStart)
    else $error("conversion start missing at compare match");

  a_sample_default: assert property (
    q.tick && !sampleCompareSel && (q.cnt == periodValue) |=> adcStart ##1 (q.cnt == CNT_RESET))
    else $error("default trigger not at the period value");

  a_eval_latency: assert property (
    samplePop |=> !evalDone [*8] ##1 evalDone)
    else $error("evaluation did not finish in ten cycles");

  a_error_form: assert property (
    samplePop |=> $signed(q.eCur) ==
      $signed({1'b0, $past(reference)}) - $signed({1'b0, $past(sampleData)}))
    else $error("error term is not reference minus sample");

  a_history_clamp: assert property (
    evalDone |-> ($signed(q.uHist[1]) <= maxLimit) && ($signed(q.uHist[1]) >= -maxLimit))
    else $error("output history outside clamp limits");

  a_coarse_split: assert property (
    evalDone |-> (q.shCoarse == q.outVal[OUT_W-1:COARSE_LSB]) && q.xferReq)
    else $error("coarse shadow does not match output bits");

  a_fine_scale: assert property (
    evalDone |-> (q.shFine < FINE_FULL_SCALE) && (q.shFine ==
      8'(((16'(q.outVal[FINE_MSB:0])) * 16'(FINE_FULL_SCALE)) >> FINE_SHIFT)))
    else $error("fine compare scaling wrong");

  a_shadow_xfer: assert property (
    boundary && q.xferReq |=> (coarseCompare == $past(q.shCoarse)) &&
      (fineCompare == $past(q.shFine)))
    else $error("shadow transfer missed at boundary");

  a_hold_compare: assert property (
    !(boundary && q.xferReq) |=> $stable(coarseCompare))
    else $error("compare changed outside a boundary");

  a_reset_clear: assert property (disable iff (1'b0)
    $past(reset) |-> (q.uHist == '0) && !q.xferReq && (coarseCompare == '0))
    else $error("reset did not clear history and compares");

endmodule
`default_nettype wire

// File: tb/adc_model.sv
// Purpose: Behavioural voltage-sampling ADC answering conversion starts
// Assumes: Samples are 12-bit unsigned and held until taken
// Notes: Burst mode streams samples to fill the sample queue
`timescale 1ns/1ps
`default_nettype none
module adc_model
  import buck_loop_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic adcStart,
  input wire logic adcReady,
  input wire logic burst,
  input wire logic [7:0] delay,
  input wire logic [ADC_W-1:0] sampleValue,
  output logic adcValid,
  output logic [ADC_W-1:0] adcData
);
  logic [7:0] waitCnt;
  logic pending;

  // Conversion time is programmable so prompt and slow answers both occur
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      adcValid <= 1'b0;
      pending <= 1'b0;
      waitCnt <= 8'h00;
      adcData <= 12'h000;
    end
    else if (adcValid && adcReady && !burst)
    begin
      adcValid <= 1'b0;
      adcData <= ~adcData; // Stale data must not look valid
    end
    else if (burst && !(adcValid && !adcReady))
    begin
      adcValid <= 1'b1;
      adcData <= sampleValue;
    end
    else if (adcStart)
    begin
      pending <= 1'b1;
      waitCnt <= delay;
    end
    else if (pending && waitCnt == 8'h00)
    begin
      pending <= 1'b0;
      adcValid <= 1'b1;
      adcData <= sampleValue;
    end
    else if (pending)
      waitCnt <= waitCnt - 8'h01;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the buck voltage-loop compensator
// Assumes: Partner ADC model answers each conversion start
// Notes: A period value of 20, so a 21-tick PWM period, keeps the run short; expectations use it
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import buck_loop_pkg::*;
;
  localparam logic [CNT_W-1:0] PER = 16'h0014;
  localparam int PCYC = (20 + 1) * TICK_DIV;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [CNT_W-1:0] periodValue = PER;
  logic sampleCompareSel = 1'b0;
  logic [CNT_W-1:0] sampleCompare = 16'h0000;
  logic [ADC_W-1:0] reference = 12'h000, sampleValue = 12'h000;
  logic signed [COEF_W-1:0] coefB0 = 16'h0001, coefB1 = 16'h0000, coefB2 = 16'h0000;
  logic signed [COEF_W-1:0] coefB3 = 16'h0000, coefA1 = 16'h0001;
  logic signed [COEF_W-1:0] coefA2 = 16'h0000, coefA3 = 16'h0000;
  logic [SHIFT_W-1:0] accShift = 6'h00;
  logic signed [U_W-1:0] maxLimit = 32'h0000_0500, minLimit = 32'h0000_0180;
  logic burst = 1'b0;
  logic [7:0] delay = 8'h04;
  logic adcStart, adcValid, adcReady, evalDone, pwmOut;
  logic [ADC_W-1:0] adcData;
  logic [COARSE_W-1:0] coarseCompare;
  logic [FINE_W-1:0] fineCompare;
  int failCount = 0;
  int comparisons = 0;

  // Free-running core clock
  always #2 core_clk = ~core_clk;

  buck_voltage_loop_compensator buck_voltage_loop_compensator_inst (
    .core_clk, .reset, .periodValue, .sampleCompareSel, .sampleCompare,
    .adcStart, .adcValid, .adcReady, .adcData, .reference,
    .coefB0, .coefB1, .coefB2, .coefB3, .coefA1, .coefA2, .coefA3,
    .accShift, .maxLimit, .minLimit, .evalDone, .coarseCompare, .fineCompare, .pwmOut
  );

  adc_model adc_model_inst (
    .core_clk, .reset, .adcStart, .adcReady, .burst, .delay, .sampleValue,
    .adcValid, .adcData
  );

  task automatic report_and_stop();
    if (failCount == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failCount++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic doReset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    check(coarseCompare, 0);
    check(fineCompare, 0);
  endtask

  // Cycles up to the next conversion start, capped at 400
  task automatic gapToStart(output int n);
    @(negedge core_clk);
    n = 1;
    while (adcStart !== 1'b1 && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic s_trigger();
    int n;
    gapToStart(n);
    gapToStart(n);
    check(n, PCYC);
    @(posedge core_clk);
    sampleCompareSel <= 1'b1;
    sampleCompare <= PER + 16'h0005;
    gapToStart(n);
    check(n, 400);
    @(posedge core_clk);
    sampleCompare <= 16'h0005;
    gapToStart(n);
    gapToStart(n);
    check(n, PCYC);
    @(posedge core_clk);
    sampleCompareSel <= 1'b0;
  endtask

  // Integrator plus direct term exercises clamp, history and floor
  task automatic s_filter();
    logic [11:0] refTab [5] = '{12'h400, 12'h400, 12'h400, 12'h000, 12'h000};
    logic [11:0] smpTab [5] = '{12'h101, 12'h101, 12'h101, 12'h2ff, 12'h2ff};
    logic [15:0] crsTab [5] = '{16'h0002, 16'h0005, 16'h0005, 16'h0002, 16'h0001};
    logic [7:0] finTab [5] = '{8'h51, 8'h00, 8'h00, 8'h00, 8'h29};
    int n;
    doReset();
    gapToStart(n);
    check(coarseCompare, 0);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge core_clk);
      reference <= refTab[i];
      sampleValue <= smpTab[i];
      delay <= (i % 2 == 1) ? 8'h1e : 8'h01;
      n = 0;
      while (evalDone !== 1'b1 && n < 100)
      begin
        @(negedge core_clk);
        n++;
      end
      check(evalDone, 1);
      gapToStart(n);
      check(coarseCompare, crsTab[i]);
      check(fineCompare, finTab[i]);
    end
    n = 0;
    for (int i = 0; i < PCYC; i++)
    begin
      @(negedge core_clk);
      if (pwmOut === 1'b1)
        n++;
    end
    check(n, 3);
  endtask

  // Queue fills while the filter is busy, then drains completely
  task automatic s_fifo();
    int acc;
    int done;
    logic full;
    acc = 0;
    done = 0;
    full = 1'b0;
    @(posedge core_clk);
    sampleCompareSel <= 1'b1;
    sampleCompare <= 16'hffff;
    coefB2 <= 16'h0002;
    accShift <= 6'h01;
    doReset();
    @(posedge core_clk);
    burst <= 1'b1;
    for (int i = 0; i < 190; i++)
    begin
      @(negedge core_clk);
      if (adcValid === 1'b1 && adcReady === 1'b1)
        acc++;
      if (adcReady === 1'b0)
        full = 1'b1;
      if (evalDone === 1'b1)
        done++;
      if (i == 40)
        burst <= 1'b0;
    end
    check(full, 1);
    check(done, acc);
  endtask

  // Hang guard, far beyond the expected run length
  initial
  begin
    #20000;
    failCount++;
    report_and_stop();
  end

  initial
  begin
    doReset();
    s_trigger();
    s_filter();
    s_fifo();
    report_and_stop();
  end
endmodule
`default_nettype wire
